// ---- apcr_audio_path_control_regs.sv ----
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
// Summary of operation
// RULE1 - All control registers reset to zero: amps off, unmuted, no mixer sources.
// RULE2 - Mixer register bit 1 mutes right loudspeaker amplifier.
// RULE3 - Mixer register bit 2 mutes left loudspeaker amplifier.
// RULE4 - Right mixer sources: bit 3 audio converter, 5 voice converter, 6 line.
// RULE5 - Left side-tone register holds six-bit volume in bits 5:0.
// RULE6 - Amplifier enable bit 0 turns on the ear piece amplifier.
// RULE7 - Amplifier enable bits 1 and 2 turn on right and left headphone.
// RULE8 - Amplifier enable bits 3 and 4 turn on right and left line-out.
// RULE9 - Amplifier enable bits 6 and 7 turn on loudspeakers; bit 5 reserved.
// RULE10 - Converter enable bits 7:6 select data bus drive strength.
// RULE11 - Switch and jack status is read-only by writes, resets to zero. The code clears status bits 0 and 1 when a one is written to them.
// RULE12 - Status bit 0 sets when power switch held over 2.0 seconds.
// RULE13 - Status bit 1 sets when a momentary switch push is detected.
// RULE14 - Status bit 2 reads zero when a headphone is present.
// RULE15 - Status bit 3 reads one when a headset is present.
// RULE16 - Mask bits 0 to 3 mask the four events; bits 7:4 reserved.
// RULE17 - Unmasked active status bit raises the interrupt; masked ones do not. The code uses sticky jack-change flags for bits 2 and 3, not the levels.
// RULE18 - Reserved bits read zero and ignore writes.
`include "apcr_map.svh"

module apcr_audio_path_control_regs #(
	parameter int unsigned LONG_PUSH_CYCLES = `APCR_LONG_PUSH_MS * 1000 * `APCR_CLK_MHZ
) (
	// Clock and reset.
	input wire logic i_ref_clk,
	input wire logic i_rst_b,
	// Register port.
	input wire apcr_pkg::apcr_addr_t i_addr,
	input wire apcr_pkg::apcr_byte_t i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output apcr_pkg::apcr_byte_t o_rdata,
	// Switch and jack sense inputs.
	input wire logic i_power_switch,
	input wire logic i_headphone_present,
	input wire logic i_headset_present,
	// Audio path controls.
	output logic o_right_loudspeaker_mute,
	output logic o_left_loudspeaker_mute,
	output logic o_right_mix_audio_conv,
	output logic o_right_mix_voice_conv,
	output logic o_right_mix_line_input,
	output logic [5:0] o_right_sidetone_level,
	output logic [5:0] o_left_sidetone_level,
	output logic o_earpiece_amp_on,
	output logic o_right_headphone_amp_on,
	output logic o_left_headphone_amp_on,
	output logic o_right_lineout_amp_on,
	output logic o_left_lineout_amp_on,
	output logic o_right_loudspeaker_amp_on,
	output logic o_left_loudspeaker_amp_on,
	output logic [5:0] o_converter_enables,
	output logic [1:0] o_bus_drive_strength,
	output logic [1:0] o_trim_enable,
	// Interrupt.
	output logic o_irq
);
	import apcr_pkg::*;

	apcr_byte_t mix_mute_r;
	apcr_byte_t right_st_r;
	apcr_byte_t left_st_r;
	apcr_byte_t amp_en_r;
	apcr_byte_t conv_en_r;
	apcr_byte_t status_word;
	apcr_byte_t mask_r;
	apcr_byte_t trim_r;
	apcr_byte_t rdata_nxt;
	apcr_sw_e sw_state_r;
	logic [31:0] hold_cnt_r;
	logic hp_prev_r;
	logic hs_prev_r;
	logic long_push_set;
	logic short_push_set;
	logic hp_change;
	logic hs_change;
	logic status_wr;
	logic [1:0] jack_level_r;
	logic long_push_flag;
	logic short_push_flag;
	logic hp_pend;
	logic hs_pend;

	// A push counts as long only once it has lasted one cycle more than the limit.
	localparam logic [31:0] LONG_PUSH_LAST = 32'(LONG_PUSH_CYCLES - 1);

	// RULE1 all zero
	// RULE18 reserved masked
	apcr_wr_reg #(
		.ADDR(`APCR_ADDR_MIX_MUTE),
		.WMASK(`APCR_WMASK_MIX_MUTE)
	) u_mix_mute_reg (
		.i_ref_clk(i_ref_clk),
		.i_rst_b(i_rst_b),
		.i_addr(i_addr),
		.i_wdata(i_wdata),
		.i_wr(i_wr),
		.o_value(mix_mute_r)
	);

	apcr_wr_reg #(
		.ADDR(`APCR_ADDR_RIGHT_ST),
		.WMASK(`APCR_WMASK_SIDETONE)
	) u_right_st_reg (
		.i_ref_clk(i_ref_clk),
		.i_rst_b(i_rst_b),
		.i_addr(i_addr),
		.i_wdata(i_wdata),
		.i_wr(i_wr),
		.o_value(right_st_r)
	);

	// RULE5 six bit volume
	apcr_wr_reg #(
		.ADDR(`APCR_ADDR_LEFT_ST),
		.WMASK(`APCR_WMASK_SIDETONE)
	) u_left_st_reg (
		.i_ref_clk(i_ref_clk),
		.i_rst_b(i_rst_b),
		.i_addr(i_addr),
		.i_wdata(i_wdata),
		.i_wr(i_wr),
		.o_value(left_st_r)
	);

	apcr_wr_reg #(
		.ADDR(`APCR_ADDR_AMP_EN),
		.WMASK(`APCR_WMASK_AMP_EN)
	) u_amp_en_reg (
		.i_ref_clk(i_ref_clk),
		.i_rst_b(i_rst_b),
		.i_addr(i_addr),
		.i_wdata(i_wdata),
		.i_wr(i_wr),
		.o_value(amp_en_r)
	);

	apcr_wr_reg #(
		.ADDR(`APCR_ADDR_CONV_EN),
		.WMASK(`APCR_WMASK_CONV_EN)
	) u_conv_en_reg (
		.i_ref_clk(i_ref_clk),
		.i_rst_b(i_rst_b),
		.i_addr(i_addr),
		.i_wdata(i_wdata),
		.i_wr(i_wr),
		.o_value(conv_en_r)
	);

	// RULE16 mask bits
	apcr_wr_reg #(
		.ADDR(`APCR_ADDR_SW_MASK),
		.WMASK(`APCR_WMASK_SW_MASK)
	) u_mask_reg (
		.i_ref_clk(i_ref_clk),
		.i_rst_b(i_rst_b),
		.i_addr(i_addr),
		.i_wdata(i_wdata),
		.i_wr(i_wr),
		.o_value(mask_r)
	);

	apcr_wr_reg #(
		.ADDR(`APCR_ADDR_TRIM_EN),
		.WMASK(`APCR_WMASK_TRIM_EN)
	) u_trim_reg (
		.i_ref_clk(i_ref_clk),
		.i_rst_b(i_rst_b),
		.i_addr(i_addr),
		.i_wdata(i_wdata),
		.i_wr(i_wr),
		.o_value(trim_r)
	);

	// RULE12 long push timer
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b) begin
			sw_state_r <= APCR_SW_IDLE;
			hold_cnt_r <= 32'h0;
		end else begin
			case (sw_state_r)
				APCR_SW_IDLE: begin
					hold_cnt_r <= 32'h0;
					if (i_power_switch) begin
						sw_state_r <= APCR_SW_HELD;
					end
				end
				APCR_SW_HELD: begin
					if (!i_power_switch) begin
						sw_state_r <= APCR_SW_IDLE;
					end else if (hold_cnt_r >= LONG_PUSH_LAST) begin
						sw_state_r <= APCR_SW_LONG;
					end else begin
						hold_cnt_r <= hold_cnt_r + 32'h1;
					end
				end
				APCR_SW_LONG: begin
					if (!i_power_switch) begin
						sw_state_r <= APCR_SW_IDLE;
					end
				end
				default: begin
					sw_state_r <= APCR_SW_IDLE;
				end
			endcase
		end
	end

	// The long event fires once on crossing the limit; a release before it counts as a momentary push.
	assign long_push_set = (sw_state_r == APCR_SW_HELD) && i_power_switch && (hold_cnt_r >= LONG_PUSH_LAST);
	// RULE13 momentary push
	assign short_push_set = (sw_state_r == APCR_SW_HELD) && !i_power_switch;

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b) begin
			// Tracking the pins during reset keeps a jack plugged at start from posting a false change.
			hp_prev_r <= i_headphone_present;
			hs_prev_r <= i_headset_present;
		end else begin
			hp_prev_r <= i_headphone_present;
			hs_prev_r <= i_headset_present;
		end
	end

	assign hp_change = hp_prev_r != i_headphone_present;
	assign hs_change = hs_prev_r != i_headset_present;
	assign status_wr = i_wr && (i_addr == `APCR_ADDR_SW_STATUS);

	// Push bits are sticky and cleared by writing one; a set in the same cycle wins.
	// Jack bits follow the jack level, so a write cannot clear them while the condition stands.
	// RULE11 no plain writes
	apcr_sticky_flag u_long_push_flag (
		.i_ref_clk(i_ref_clk),
		.i_rst_b(i_rst_b),
		.i_set(long_push_set),
		.i_clear(status_wr && i_wdata[`APCR_BIT_LONG_PUSH]),
		.o_flag(long_push_flag)
	);

	apcr_sticky_flag u_short_push_flag (
		.i_ref_clk(i_ref_clk),
		.i_rst_b(i_rst_b),
		.i_set(short_push_set),
		.i_clear(status_wr && i_wdata[`APCR_BIT_SHORT_PUSH]),
		.o_flag(short_push_flag)
	);

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b) begin
			jack_level_r <= 2'h0;
		end else begin
			// RULE14 inverted headphone
			// RULE15 headset level
			jack_level_r <= {i_headset_present, !i_headphone_present};
		end
	end

	assign status_word = {4'h0, jack_level_r, short_push_flag, long_push_flag};

	// Jack changes are reported through the interrupt via a sticky pending pair.
	apcr_sticky_flag u_hp_pend_flag (
		.i_ref_clk(i_ref_clk),
		.i_rst_b(i_rst_b),
		.i_set(hp_change),
		.i_clear(status_wr && i_wdata[`APCR_BIT_HP_EVENT]),
		.o_flag(hp_pend)
	);

	apcr_sticky_flag u_hs_pend_flag (
		.i_ref_clk(i_ref_clk),
		.i_rst_b(i_rst_b),
		.i_set(hs_change),
		.i_clear(status_wr && i_wdata[`APCR_BIT_HS_EVENT]),
		.o_flag(hs_pend)
	);

	// RULE17 masked interrupt
	assign o_irq = |({hs_pend, hp_pend, status_word[1:0]} & ~mask_r[3:0]);

	always_comb begin
		rdata_nxt = 8'h00;
		if (i_addr == `APCR_ADDR_MIX_MUTE) begin
			rdata_nxt = mix_mute_r;
		end else if (i_addr == `APCR_ADDR_RIGHT_ST) begin
			rdata_nxt = right_st_r;
		end else if (i_addr == `APCR_ADDR_LEFT_ST) begin
			rdata_nxt = left_st_r;
		end else if (i_addr == `APCR_ADDR_AMP_EN) begin
			rdata_nxt = amp_en_r;
		end else if (i_addr == `APCR_ADDR_CONV_EN) begin
			rdata_nxt = conv_en_r;
		end else if (i_addr == `APCR_ADDR_SW_STATUS) begin
			rdata_nxt = status_word;
		end else if (i_addr == `APCR_ADDR_SW_MASK) begin
			rdata_nxt = mask_r;
		end else if (i_addr == `APCR_ADDR_TRIM_EN) begin
			rdata_nxt = trim_r;
		end
	end

	// Read data holds only in the cycle after the strobe.
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b) begin
			o_rdata <= 8'h00;
		end else if (i_rd) begin
			o_rdata <= rdata_nxt;
		end else begin
			o_rdata <= 8'h00;
		end
	end

	// RULE2 right mute
	assign o_right_loudspeaker_mute = mix_mute_r[`APCR_BIT_RSPK_MUTE];
	// RULE3 left mute
	assign o_left_loudspeaker_mute = mix_mute_r[`APCR_BIT_LSPK_MUTE];
	// RULE4 mixer sources
	assign o_right_mix_audio_conv = mix_mute_r[`APCR_BIT_MIX_AUD];
	assign o_right_mix_voice_conv = mix_mute_r[`APCR_BIT_MIX_VOICE];
	assign o_right_mix_line_input = mix_mute_r[`APCR_BIT_MIX_LINE];
	assign o_right_sidetone_level = right_st_r[5:0];
	assign o_left_sidetone_level = left_st_r[5:0];
	// RULE6 earpiece enable
	assign o_earpiece_amp_on = amp_en_r[`APCR_BIT_EAR_ON];
	// RULE7 headphone enables
	assign o_right_headphone_amp_on = amp_en_r[`APCR_BIT_RHP_ON];
	assign o_left_headphone_amp_on = amp_en_r[`APCR_BIT_LHP_ON];
	// RULE8 lineout enables
	assign o_right_lineout_amp_on = amp_en_r[`APCR_BIT_RLO_ON];
	assign o_left_lineout_amp_on = amp_en_r[`APCR_BIT_LLO_ON];
	// RULE9 loudspeaker enables
	assign o_right_loudspeaker_amp_on = amp_en_r[`APCR_BIT_RSPK_ON];
	assign o_left_loudspeaker_amp_on = amp_en_r[`APCR_BIT_LSPK_ON];
	assign o_converter_enables = conv_en_r[5:0];
	// RULE10 drive strength
	assign o_bus_drive_strength = conv_en_r[7:6];
	assign o_trim_enable = trim_r[1:0];
endmodule // apcr_audio_path_control_regs

// One software-writable byte; reserved positions never take a one.
module apcr_wr_reg #(
	parameter apcr_pkg::apcr_addr_t ADDR = 9'h000,
	parameter apcr_pkg::apcr_byte_t WMASK = 8'hFF
) (
	// Clock and reset.
	input wire logic i_ref_clk,
	input wire logic i_rst_b,
	// Register port.
	input wire apcr_pkg::apcr_addr_t i_addr,
	input wire apcr_pkg::apcr_byte_t i_wdata,
	input wire logic i_wr,
	// Stored value.
	output apcr_pkg::apcr_byte_t o_value
);
	import apcr_pkg::*;

	// RULE1 zero reset
	// RULE18 reserved bits
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b) begin
			o_value <= `APCR_RESET_VAL;
		end else if (i_wr && (i_addr == ADDR)) begin
			o_value <= i_wdata & WMASK;
		end
	end
endmodule // apcr_wr_reg

// Sticky event flag cleared by writing one; a set in the clearing cycle wins so no event is lost.
module apcr_sticky_flag (
	// Clock and reset.
	input wire logic i_ref_clk,
	input wire logic i_rst_b,
	// Event and software clear.
	input wire logic i_set,
	input wire logic i_clear,
	// Flag.
	output logic o_flag
);
	import apcr_pkg::*;

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b) begin
			o_flag <= 1'b0;
		end else if (i_set) begin
			o_flag <= 1'b1;
		end else if (i_clear) begin
			o_flag <= 1'b0;
		end
	end
endmodule // apcr_sticky_flag

// ---- apcr_audio_path_control_regs_chk.sv ----
`timescale 1ns/1ps
`include "apcr_map.svh"
module apcr_audio_path_control_regs_chk #(
	parameter int unsigned LONG_PUSH_CYCLES = 20
) (
	// Clock, reset and register port.
	input wire logic i_ref_clk,
	input wire logic i_rst_b,
	input wire apcr_pkg::apcr_addr_t i_addr,
	input wire apcr_pkg::apcr_byte_t i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire apcr_pkg::apcr_byte_t o_rdata,
	// Jack inputs and watched controls.
	input wire logic i_headphone_present,
	input wire logic i_headset_present,
	input wire logic o_right_loudspeaker_mute,
	input wire logic o_left_loudspeaker_mute,
	input wire logic o_earpiece_amp_on,
	input wire logic [5:0] o_left_sidetone_level,
	input wire logic [1:0] o_bus_drive_strength
);
	import apcr_pkg::*;
	default clocking @(posedge i_ref_clk);
	endclocking
	default disable iff (!i_rst_b);
	a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
		else $error("read data outside its slot");
	a_unmapped_zero: assert property (i_rd && i_addr > `APCR_ADDR_TRIM_EN |=> o_rdata == 8'h00)
		else $error("unmapped read not zero");
	a_status_rsvd: assert property (i_rd && i_addr == `APCR_ADDR_SW_STATUS |=> o_rdata[7:4] == 4'h0)
		else $error("status upper bits not zero");
	a_jack_level: assert property (i_rd && i_addr == `APCR_ADDR_SW_STATUS && $stable(i_headphone_present)
		&& $stable(i_headset_present) |=> o_rdata[3:2] == {$past(i_headset_present), !$past(i_headphone_present)})
		else $error("jack status bits wrong");
	a_left_level: assert property (i_wr && i_addr == `APCR_ADDR_LEFT_ST |=> o_left_sidetone_level == $past(i_wdata[5:0]))
		else $error("left side-tone level not written");
	a_drive_write: assert property (i_wr && i_addr == `APCR_ADDR_CONV_EN |=> o_bus_drive_strength == $past(i_wdata[7:6]))
		else $error("drive strength not written");
	a_mute_write: assert property (i_wr && i_addr == `APCR_ADDR_MIX_MUTE
		|=> {o_left_loudspeaker_mute, o_right_loudspeaker_mute} == $past(i_wdata[2:1]))
		else $error("loudspeaker mutes not written");
	a_ear_write: assert property (i_wr && i_addr == `APCR_ADDR_AMP_EN |=> o_earpiece_amp_on == $past(i_wdata[0]))
		else $error("ear piece enable not written");
endmodule // apcr_audio_path_control_regs_chk

bind apcr_audio_path_control_regs apcr_audio_path_control_regs_chk #(.LONG_PUSH_CYCLES(LONG_PUSH_CYCLES)) u_chk (
	.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
	.o_rdata(o_rdata), .i_headphone_present(i_headphone_present), .i_headset_present(i_headset_present),
	.o_right_loudspeaker_mute(o_right_loudspeaker_mute), .o_left_loudspeaker_mute(o_left_loudspeaker_mute),
	.o_earpiece_amp_on(o_earpiece_amp_on), .o_left_sidetone_level(o_left_sidetone_level),
	.o_bus_drive_strength(o_bus_drive_strength));

// ---- apcr_audio_path_control_regs_tb.sv ----
`timescale 1ns/1ps
`include "apcr_map.svh"
module apcr_audio_path_control_regs_tb;
	import apcr_pkg::*;
	localparam int LP = 20;
	logic i_ref_clk, i_rst_b, i_wr, i_rd, i_power_switch, i_headphone_present, i_headset_present, o_irq;
	apcr_addr_t i_addr;
	apcr_byte_t i_wdata, o_rdata;
	wire [7:0] mix, amp, conv;
	wire [5:0] rs, ls;
	wire [1:0] trim;
	// Reserved positions have no port, so they are tied low.
	assign mix[0] = 1'b0;
	assign mix[4] = 1'b0;
	assign mix[7] = 1'b0;
	assign amp[5] = 1'b0;
	int err_count = 0;
	int tests_run = 0;
	apcr_addr_t regs [7] = '{`APCR_ADDR_MIX_MUTE, `APCR_ADDR_RIGHT_ST, `APCR_ADDR_LEFT_ST, `APCR_ADDR_AMP_EN,
		`APCR_ADDR_CONV_EN, `APCR_ADDR_SW_MASK, `APCR_ADDR_TRIM_EN};
	apcr_byte_t wmk [7] = '{`APCR_WMASK_MIX_MUTE, `APCR_WMASK_SIDETONE, `APCR_WMASK_SIDETONE, `APCR_WMASK_AMP_EN,
		`APCR_WMASK_CONV_EN, `APCR_WMASK_SW_MASK, `APCR_WMASK_TRIM_EN};
	apcr_byte_t pats [4] = '{8'hFF, 8'hA5, 8'h5A, 8'h00};
	apcr_addr_t bad [4] = '{9'h000, 9'h191, 9'h19A, 9'h1FF};
	apcr_audio_path_control_regs #(.LONG_PUSH_CYCLES(LP)) dut (
		.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
		.o_rdata(o_rdata), .i_power_switch(i_power_switch), .i_headphone_present(i_headphone_present),
		.i_headset_present(i_headset_present), .o_right_loudspeaker_mute(mix[1]), .o_left_loudspeaker_mute(mix[2]),
		.o_right_mix_audio_conv(mix[3]), .o_right_mix_voice_conv(mix[5]), .o_right_mix_line_input(mix[6]),
		.o_right_sidetone_level(rs), .o_left_sidetone_level(ls), .o_earpiece_amp_on(amp[0]),
		.o_right_headphone_amp_on(amp[1]), .o_left_headphone_amp_on(amp[2]), .o_right_lineout_amp_on(amp[3]),
		.o_left_lineout_amp_on(amp[4]), .o_right_loudspeaker_amp_on(amp[6]), .o_left_loudspeaker_amp_on(amp[7]),
		.o_converter_enables(conv[5:0]), .o_bus_drive_strength(conv[7:6]), .o_trim_enable(trim), .o_irq(o_irq));
	initial begin
		i_ref_clk = 1'b0;
		forever #2.5 i_ref_clk = ~i_ref_clk;
	end
	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic chk(input string n, input apcr_byte_t e, input apcr_byte_t g);
		tests_run++;
		if (g !== e) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask
	// Gathers the control ports back into register layout, unmasked so a stray bit shows.
	function automatic apcr_byte_t pv(input int i);
		apcr_byte_t v [7];
		v = '{mix, {2'b00, rs}, {2'b00, ls}, amp, conv, 8'h00, {6'h00, trim}};
		return v[i];
	endfunction
	task automatic wr(input apcr_addr_t a, input apcr_byte_t d);
		@(posedge i_ref_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_ref_clk);
		i_wr <= 1'b0;
		#1;
	endtask
	task automatic rd(input apcr_addr_t a, input apcr_byte_t e);
		@(posedge i_ref_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_ref_clk);
		i_rd <= 1'b0;
		#1;
		chk($sformatf("register %h", a), e, o_rdata);
	endtask
	task automatic irq_is(input logic e);
		chk("interrupt", {7'h00, e}, {7'h00, o_irq});
	endtask
	// The switch is released long enough for the push to be classified before the next access.
	task automatic press(input int n);
		@(posedge i_ref_clk);
		i_power_switch <= 1'b1;
		repeat (n) @(posedge i_ref_clk);
		i_power_switch <= 1'b0;
		repeat (4) @(posedge i_ref_clk);
	endtask
	task automatic jacks(input logic hp, input logic hs);
		@(posedge i_ref_clk);
		i_headphone_present <= hp;
		i_headset_present <= hs;
		repeat (4) @(posedge i_ref_clk);
	endtask
	initial begin
		repeat (20000) @(posedge i_ref_clk);
		err_count++;
		stop_test();
	end
	initial begin
		i_rst_b = 1'b0;
		i_addr = 9'h000;
		i_wdata = 8'h00;
		i_wr = 1'b0;
		i_rd = 1'b0;
		i_power_switch = 1'b0;
		i_headphone_present = 1'b0;
		i_headset_present = 1'b0;
		repeat (16) @(posedge i_ref_clk);
		i_rst_b <= 1'b1;
		foreach (regs[i]) rd(regs[i], 8'h00);
		rd(`APCR_ADDR_SW_STATUS, 8'h04);
		irq_is(1'b0);
		foreach (pats[p]) begin
			foreach (regs[i]) begin
				wr(regs[i], pats[p]);
				rd(regs[i], pats[p] & wmk[i]);
				chk("control port", (i == 5) ? 8'h00 : pats[p] & wmk[i], pv(i));
			end
		end
		foreach (bad[i]) begin
			wr(bad[i], 8'hFF);
			rd(bad[i], 8'h00);
		end
		rd(`APCR_ADDR_MIX_MUTE, 8'h00);
		wr(`APCR_ADDR_SW_STATUS, 8'hFF);
		rd(`APCR_ADDR_SW_STATUS, 8'h04);
		jacks(1'b1, 1'b1);
		rd(`APCR_ADDR_SW_STATUS, 8'h08);
		irq_is(1'b1);
		wr(`APCR_ADDR_SW_STATUS, 8'h0C);
		irq_is(1'b0);
		wr(`APCR_ADDR_SW_MASK, 8'h0F);
		jacks(1'b0, 1'b1);
		irq_is(1'b0);
		wr(`APCR_ADDR_SW_MASK, 8'h00);
		irq_is(1'b1);
		wr(`APCR_ADDR_SW_STATUS, 8'h0C);
		rd(`APCR_ADDR_SW_STATUS, 8'h0C);
		press(LP - 1);
		rd(`APCR_ADDR_SW_STATUS, 8'h0E);
		irq_is(1'b1);
		wr(`APCR_ADDR_SW_STATUS, 8'h02);
		rd(`APCR_ADDR_SW_STATUS, 8'h0C);
		press(LP);
		rd(`APCR_ADDR_SW_STATUS, 8'h0E);
		wr(`APCR_ADDR_SW_STATUS, 8'h02);
		press(LP + 1);
		rd(`APCR_ADDR_SW_STATUS, 8'h0D);
		wr(`APCR_ADDR_SW_STATUS, 8'h01);
		rd(`APCR_ADDR_SW_STATUS, 8'h0C);
		wr(`APCR_ADDR_SW_MASK, 8'h01);
		press(LP + 3);
		rd(`APCR_ADDR_SW_STATUS, 8'h0D);
		irq_is(1'b0);
		wr(`APCR_ADDR_SW_MASK, 8'h00);
		irq_is(1'b1);
		wr(`APCR_ADDR_SW_STATUS, 8'h01);
		irq_is(1'b0);
		stop_test();
	end
endmodule // apcr_audio_path_control_regs_tb

// ---- apcr_map.svh ----
`ifndef APCR_MAP_SVH
`define APCR_MAP_SVH

// Register addresses.
`define APCR_ADDR_MIX_MUTE 9'h192
`define APCR_ADDR_RIGHT_ST 9'h193
`define APCR_ADDR_LEFT_ST 9'h194
`define APCR_ADDR_AMP_EN 9'h195
`define APCR_ADDR_CONV_EN 9'h196
`define APCR_ADDR_SW_STATUS 9'h197
`define APCR_ADDR_SW_MASK 9'h198
`define APCR_ADDR_TRIM_EN 9'h199

// Writable bit masks; cleared positions are reserved.
`define APCR_WMASK_MIX_MUTE 8'h6E
`define APCR_WMASK_SIDETONE 8'h3F
`define APCR_WMASK_AMP_EN 8'hDF
`define APCR_WMASK_CONV_EN 8'hFF
`define APCR_WMASK_SW_MASK 8'h0F
`define APCR_WMASK_TRIM_EN 8'h03

// Field positions.
`define APCR_BIT_RSPK_MUTE 1
`define APCR_BIT_LSPK_MUTE 2
`define APCR_BIT_MIX_AUD 3
`define APCR_BIT_MIX_VOICE 5
`define APCR_BIT_MIX_LINE 6
`define APCR_BIT_EAR_ON 0
`define APCR_BIT_RHP_ON 1
`define APCR_BIT_LHP_ON 2
`define APCR_BIT_RLO_ON 3
`define APCR_BIT_LLO_ON 4
`define APCR_BIT_RSPK_ON 6
`define APCR_BIT_LSPK_ON 7
`define APCR_BIT_LONG_PUSH 0
`define APCR_BIT_SHORT_PUSH 1
`define APCR_BIT_HP_EVENT 2
`define APCR_BIT_HS_EVENT 3

// Reset value and long push timing.
`define APCR_RESET_VAL 8'h00
`define APCR_LONG_PUSH_MS 2000
`define APCR_CLK_MHZ 200

`endif

// ---- apcr_pkg.sv ----
package apcr_pkg;
	typedef logic [8:0] apcr_addr_t;
	typedef logic [7:0] apcr_byte_t;
	typedef enum logic [1:0] {
		APCR_SW_IDLE,
		APCR_SW_HELD,
		APCR_SW_LONG
	} apcr_sw_e;
endpackage
